// ===== rx_ctrl_consts.svh
// Offsets, field positions, reset values and encodings of the receive control block.
// Included by the top module and the testbench; definitions only.
`ifndef RX_CTRL_CONSTS_SVH
`define RX_CTRL_CONSTS_SVH

// Register byte offsets
`define OFF_RECEIVE_CONTROL 8'h00
`define OFF_IRQ_STATUS 8'h04
`define OFF_IRQ_MASK 8'h08
`define OFF_RING_LENGTH 8'h0c
`define OFF_FLEX_BUF 8'h10
`define OFF_SPLIT_BUF 8'h14
`define OFF_MTA_INDEX 8'h18
`define OFF_MTA_DATA 8'h1c
`define OFF_BUF_SIZE_STAT 8'h20

// Writable bits of receive_control; 14 and 21 to 24 stay zero
`define CTRL_WMASK 32'h021fbfc0
`define CTRL_RESET 32'h00000000
`define LOOP_SEL_LO 6
`define FDT_LO 8
`define DESC_FMT_LO 10
`define MC_OFS_LO 12
`define BCAST_ACC_BIT 15
`define BUF_CODE_LO 16
`define VLAN_FILT_BIT 18
`define CANON_EN_BIT 19
`define CANON_VAL_BIT 20
`define BUF_EXT_BIT 25

// Encodings
`define LOOP_MAC 2'h1
`define DESC_SPLIT 2'h1
`define FDT_RSVD 2'h3
`define BUF_SIZE_BASE 17'h00800
`define BUF_EXT_SHIFT 4
`define FLEX_SHIFT 10
`define MCAST_BIT 40
`define IRQ_MIN_THR 0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define SPLIT_RESET 17'h00800
`endif

// ===== rx_ctrl_pkg.sv
// Types shared by the receive control block.
// Assumes rx_ctrl_consts.svh is in the include path.
package rx_ctrl_pkg;
    typedef struct packed {
        logic [31:0] ctrl;
        logic irq_stat;
        logic irq_mask;
        logic [12:0] ring_len;
        logic [3:0] flex_buf;
        logic [16:0] split_buf;
        logic [6:0] mta_idx;
        logic [127:0][31:0] mta;
        logic thr_eq;
        logic [1:0][8:0] rx_sync;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic irq;
        logic [7:0] rx_data;
        logic rx_valid;
        logic loop_active;
        logic acc_valid;
        logic acc;
        logic [16:0] buf_size;
    } state_t;
endpackage

// ===== rx_ctrl_filter.sv
// Receive control: loopback select, free-descriptor threshold interrupt, buffer sizing,
// multicast/broadcast/VLAN acceptance, with AXI4-Lite register access.
// Assumes frame header fields arrive on clk_i from the parser; PHY receive pins are asynchronous.
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "rx_ctrl_consts.svh"

module rx_ctrl_filter
    import rx_ctrl_pkg::*;
(
    input wire logic clk_i, // 250 MHz controller clock
    input wire logic rst_n_i, // Synchronous reset, active low
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr_i, // Write address
    input wire logic s_axi_awvalid_i, // Write address valid
    output logic s_axi_awready_o, // Write address ready
    input wire logic [31:0] s_axi_wdata_i, // Write data
    input wire logic [3:0] s_axi_wstrb_i, // Byte strobes
    input wire logic s_axi_wvalid_i, // Write data valid
    output logic s_axi_wready_o, // Write data ready
    output logic [1:0] s_axi_bresp_o, // Write response
    output logic s_axi_bvalid_o, // Write response valid
    input wire logic s_axi_bready_i, // Write response ready
    input wire logic [7:0] s_axi_araddr_i, // Read address
    input wire logic s_axi_arvalid_i, // Read address valid
    output logic s_axi_arready_o, // Read address ready
    output logic [31:0] s_axi_rdata_o, // Read data
    output logic [1:0] s_axi_rresp_o, // Read response
    output logic s_axi_rvalid_o, // Read data valid
    input wire logic s_axi_rready_i, // Read data ready
    output logic irq_o, // Level interrupt
    // Descriptor ring state from DMA
    input wire logic [12:0] free_desc_count_i, // Free receive descriptors
    // Data paths
    input wire logic [7:0] tx_data_i, // Transmit byte toward PHY
    input wire logic tx_valid_i, // Transmit byte valid
    input wire logic [7:0] phy_rx_data_i, // PHY receive byte, async
    input wire logic phy_rx_valid_i, // PHY receive valid, async
    output logic [7:0] rx_data_o, // Receive byte to MAC
    output logic rx_valid_o, // Receive byte valid
    output logic loopback_active_o, // MAC loopback selected
    // Frame header for acceptance
    input wire logic frame_valid_i, // Header fields valid, one cycle
    input wire logic [47:0] frame_dst_addr_i, // Destination address, first octet in 47:40
    input wire logic frame_addr_match_i, // Perfect or imperfect filter hit
    input wire logic frame_tagged_i, // Carries 802.1Q tag
    input wire logic frame_cfi_i, // CFI bit of tag
    input wire logic frame_vlan_hit_i, // VLAN table hit for tag id
    output logic accept_valid_o, // Decision valid, one cycle
    output logic accept_o, // Frame accepted
    output logic [16:0] buffer_size_o // Effective receive buffer bytes
);

    state_t s_reg;
    state_t s_next;

    // Field views of the current control register
    logic [1:0] loop_sel;
    logic [1:0] fdt;
    logic [1:0] desc_fmt;
    logic [1:0] mc_ofs;
    logic [1:0] buf_code;
    logic [12:0] thr;
    logic thr_eq_now;
    logic [11:0] mta_bit;
    logic is_bcast;
    logic is_mcast;
    logic tag_ok;
    logic [16:0] size_sel;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_hit;
    logic [31:0] wmask;
    logic wr_fire;
    logic rd_fire;

    assign loop_sel = s_reg.ctrl[`LOOP_SEL_LO +: 2];
    assign fdt = s_reg.ctrl[`FDT_LO +: 2];
    assign desc_fmt = s_reg.ctrl[`DESC_FMT_LO +: 2];
    assign mc_ofs = s_reg.ctrl[`MC_OFS_LO +: 2];
    assign buf_code = s_reg.ctrl[`BUF_CODE_LO +: 2];

    // Threshold: ring length shifted by 1, 2 or 3 places
    assign thr = s_reg.ring_len >> (fdt + 2'h1);
    // Reserved code and an empty ring never fire: no guessed fraction, no false event after reset
    assign thr_eq_now = (fdt != `FDT_RSVD) && (s_reg.ring_len != 13'h0) && (free_desc_count_i == thr);

    // Multicast table index selection
    always_comb begin
        unique case (mc_ofs)
            2'h0: mta_bit = frame_dst_addr_i[47:36];
            2'h1: mta_bit = frame_dst_addr_i[46:35];
            2'h2: mta_bit = frame_dst_addr_i[45:34];
            2'h3: mta_bit = frame_dst_addr_i[43:32];
        endcase
    end

    assign is_bcast = &frame_dst_addr_i;
    assign is_mcast = frame_dst_addr_i[`MCAST_BIT];

    // Tag checks apply to tagged frames only
    assign tag_ok = !frame_tagged_i
        || ((!s_reg.ctrl[`VLAN_FILT_BIT] || frame_vlan_hit_i)
        && (!s_reg.ctrl[`CANON_EN_BIT] || (frame_cfi_i == s_reg.ctrl[`CANON_VAL_BIT])));

    // Buffer size: flexible setting, split control, then legacy field
    always_comb begin
        size_sel = `BUF_SIZE_BASE >> buf_code;
        if (s_reg.ctrl[`BUF_EXT_BIT]) begin
            size_sel = size_sel << `BUF_EXT_SHIFT;
        end
        if (s_reg.flex_buf != 4'h0) begin
            size_sel = 17'(s_reg.flex_buf) << `FLEX_SHIFT;
        end else if (desc_fmt == `DESC_SPLIT) begin
            size_sel = s_reg.split_buf;
        end
    end

    // Read decode
    always_comb begin
        rd_hit = 1'b1;
        rd_word = 32'h00000000;
        unique case (s_axi_araddr_i)
            `OFF_RECEIVE_CONTROL: rd_word = s_reg.ctrl & `CTRL_WMASK;
            `OFF_IRQ_STATUS: rd_word[`IRQ_MIN_THR] = s_reg.irq_stat;
            `OFF_IRQ_MASK: rd_word[`IRQ_MIN_THR] = s_reg.irq_mask;
            `OFF_RING_LENGTH: rd_word[12:0] = s_reg.ring_len;
            `OFF_FLEX_BUF: rd_word[3:0] = s_reg.flex_buf;
            `OFF_SPLIT_BUF: rd_word[16:0] = s_reg.split_buf;
            `OFF_MTA_INDEX: rd_word[6:0] = s_reg.mta_idx;
            `OFF_MTA_DATA: rd_word = s_reg.mta[s_reg.mta_idx];
            `OFF_BUF_SIZE_STAT: rd_word[16:0] = s_reg.buf_size;
            default: rd_hit = 1'b0;
        endcase
    end

    // Byte-lane mask for writes
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{s_reg.w_strb[i]}};
        end
    end

    assign wr_fire = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
    assign rd_fire = s_axi_arvalid_i && s_reg.arready;

    always_comb begin
        unique case (s_reg.aw_addr)
            `OFF_RECEIVE_CONTROL, `OFF_IRQ_STATUS, `OFF_IRQ_MASK, `OFF_RING_LENGTH,
            `OFF_FLEX_BUF, `OFF_SPLIT_BUF, `OFF_MTA_INDEX, `OFF_MTA_DATA,
            `OFF_BUF_SIZE_STAT: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Next-state logic for the whole block
    always_comb begin
        logic [31:0] merged;
        logic [31:0] wd;
        s_next = s_reg;
        wd = s_reg.w_data & wmask;
        merged = 32'h00000000;

        // Address and data channels taken independently, in either order
        if (s_axi_awvalid_i && s_reg.awready) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_reg.wready) begin
            s_next.w_held = 1'b1;
            s_next.w_data = s_axi_wdata_i;
            s_next.w_strb = s_axi_wstrb_i;
        end

        // Register write once both halves are held
        if (wr_fire) begin
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            unique case (s_reg.aw_addr)
                `OFF_RECEIVE_CONTROL: begin
                    merged = (s_reg.ctrl & ~wmask) | wd;
                    s_next.ctrl = merged & `CTRL_WMASK;
                end
                `OFF_IRQ_MASK: begin
                    if (s_reg.w_strb[0]) begin
                        s_next.irq_mask = s_reg.w_data[`IRQ_MIN_THR];
                    end
                end
                `OFF_RING_LENGTH: begin
                    merged = (32'(s_reg.ring_len) & ~wmask) | wd;
                    s_next.ring_len = merged[12:0];
                end
                `OFF_FLEX_BUF: begin
                    if (s_reg.w_strb[0]) begin
                        s_next.flex_buf = s_reg.w_data[3:0];
                    end
                end
                `OFF_SPLIT_BUF: begin
                    merged = (32'(s_reg.split_buf) & ~wmask) | wd;
                    s_next.split_buf = merged[16:0];
                end
                `OFF_MTA_INDEX: begin
                    if (s_reg.w_strb[0]) begin
                        s_next.mta_idx = s_reg.w_data[6:0];
                    end
                end
                `OFF_MTA_DATA: begin
                    s_next.mta[s_reg.mta_idx] = (s_reg.mta[s_reg.mta_idx] & ~wmask) | wd;
                end
                default: begin
                end
            endcase
        end
        if (s_reg.bvalid && s_axi_bready_i) begin
            s_next.bvalid = 1'b0;
        end
        // Ready only while the holding slot is free and no response waits
        s_next.awready = !s_next.aw_held && !s_next.bvalid;
        s_next.wready = !s_next.w_held && !s_next.bvalid;

        // Read path: one outstanding read, data one cycle after address
        if (rd_fire) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = rd_word;
            s_next.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            if (s_axi_araddr_i == `OFF_IRQ_STATUS) begin
                s_next.irq_stat = 1'b0; // Read clears
            end
        end else if (s_reg.rvalid && s_axi_rready_i) begin
            s_next.rvalid = 1'b0;
        end
        s_next.arready = !s_next.rvalid;

        // Threshold event on entry into equality; set beats read clear
        s_next.thr_eq = thr_eq_now;
        if (thr_eq_now && !s_reg.thr_eq) begin
            s_next.irq_stat = 1'b1;
        end
        s_next.irq = s_next.irq_stat && s_next.irq_mask;

        // Two-flop synchroniser for PHY pins; only stage 1 is read
        s_next.rx_sync[0] = {phy_rx_valid_i, phy_rx_data_i};
        s_next.rx_sync[1] = s_reg.rx_sync[0];

        // Undefined and reserved codes fall back to normal operation
        s_next.loop_active = (loop_sel == `LOOP_MAC);
        if (s_reg.loop_active) begin
            s_next.rx_data = tx_data_i;
            s_next.rx_valid = tx_valid_i;
        end else begin
            s_next.rx_data = s_reg.rx_sync[1][7:0];
            s_next.rx_valid = s_reg.rx_sync[1][8];
        end

        // Acceptance decision, registered one cycle after the header
        s_next.acc_valid = frame_valid_i;
        if (!tag_ok) begin
            s_next.acc = 1'b0;
        end else if (is_bcast) begin
            s_next.acc = s_reg.ctrl[`BCAST_ACC_BIT] || frame_addr_match_i;
        end else if (is_mcast) begin
            s_next.acc = frame_addr_match_i || s_reg.mta[mta_bit[11:5]][mta_bit[4:0]];
        end else begin
            s_next.acc = frame_addr_match_i;
        end

        s_next.buf_size = size_sel;
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_reg <= '0;
            s_reg.ctrl <= `CTRL_RESET;
            s_reg.split_buf <= `SPLIT_RESET;
            s_reg.buf_size <= `BUF_SIZE_BASE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign s_axi_awready_o = s_reg.awready;
    assign s_axi_wready_o = s_reg.wready;
    assign s_axi_bvalid_o = s_reg.bvalid;
    assign s_axi_bresp_o = s_reg.bresp;
    assign s_axi_arready_o = s_reg.arready;
    assign s_axi_rvalid_o = s_reg.rvalid;
    assign s_axi_rdata_o = s_reg.rdata;
    assign s_axi_rresp_o = s_reg.rresp;
    assign irq_o = s_reg.irq;
    assign rx_data_o = s_reg.rx_data;
    assign rx_valid_o = s_reg.rx_valid;
    assign loopback_active_o = s_reg.loop_active;
    assign accept_valid_o = s_reg.acc_valid;
    assign accept_o = s_reg.acc;
    assign buffer_size_o = s_reg.buf_size;

endmodule // rx_ctrl_filter

// ===== rx_ctrl_filter_properties.sv
// Port-level checker for the receive control block.
// Bound into every rx_ctrl_filter; sees only the ports below.
`timescale 1ns/100ps
module rx_ctrl_filter_properties (
    input wire logic clk_i, // Clock
    input wire logic rst_n_i, // Reset, active low
    input wire logic s_axi_awready_o, // Write address ready
    input wire logic s_axi_wready_o, // Write data ready
    input wire logic [1:0] s_axi_bresp_o, // Write response
    input wire logic s_axi_bvalid_o, // Write response valid
    input wire logic s_axi_bready_i, // Write response ready
    input wire logic s_axi_arvalid_i, // Read address valid
    input wire logic s_axi_arready_o, // Read address ready
    input wire logic [31:0] s_axi_rdata_o, // Read data
    input wire logic s_axi_rvalid_o, // Read data valid
    input wire logic s_axi_rready_i, // Read data ready
    input wire logic [7:0] tx_data_i, // Transmit byte
    input wire logic [7:0] rx_data_o, // Receive byte
    input wire logic loopback_active_o, // Loopback selected
    input wire logic frame_valid_i, // Header valid
    input wire logic [47:0] frame_dst_addr_i, // Destination address
    input wire logic frame_addr_match_i, // Address filter hit
    input wire logic frame_tagged_i, // Tagged frame
    input wire logic accept_valid_o, // Decision valid
    input wire logic accept_o // Decision
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Answers hold until the master takes them
    a_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped early");
    a_rvalid_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped early");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
        else $error("read answer late");
    a_write_reopen: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o ##1 (s_axi_awready_o && s_axi_wready_o))
        else $error("write channel not reopened");
    a_bresp_code: assert property (s_axi_bvalid_o |-> s_axi_bresp_o == 2'h0 || s_axi_bresp_o == 2'h2)
        else $error("bad write response code");
    // One decision per isolated header
    a_accept_pulse: assert property (frame_valid_i ##1 !frame_valid_i |-> accept_valid_o ##1 !accept_valid_o)
        else $error("decision pulse wrong");
    a_bcast_match: assert property (frame_valid_i && &frame_dst_addr_i && frame_addr_match_i && !frame_tagged_i
        |=> accept_o)
        else $error("matching broadcast dropped");
    // Two cycles of loopback so the path switch has settled
    a_loop_data: assert property (loopback_active_o && $past(loopback_active_o, 2) |-> rx_data_o == $past(tx_data_i))
        else $error("loopback byte wrong");

    c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
    c_accept: cover property (accept_valid_o && accept_o);
    c_loop: cover property (loopback_active_o);
endmodule // rx_ctrl_filter_properties

bind rx_ctrl_filter rx_ctrl_filter_properties rx_ctrl_filter_properties_i (.clk_i, .rst_n_i, .s_axi_awready_o,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i, .tx_data_i, .rx_data_o, .loopback_active_o, .frame_valid_i,
    .frame_dst_addr_i, .frame_addr_match_i, .frame_tagged_i, .accept_valid_o, .accept_o);

// ===== phy_rx_model.sv
// Behavioural PHY receive side: sends single bytes on request.
// Assumes the receiver synchronises these lines itself.
`timescale 1ns/100ps
module phy_rx_model (
    input wire logic clk_i, // Clock
    input wire logic send_i, // Send one byte
    input wire logic [7:0] byte_i, // Byte to send
    output logic [7:0] phy_rx_data_o = 8'h00, // Receive data
    output logic phy_rx_valid_o = 1'b0 // Receive valid
);
    // Idle data toggles so a stale byte never passes for a fresh one
    always @(posedge clk_i) begin
        phy_rx_valid_o <= send_i;
        phy_rx_data_o <= send_i ? byte_i : ~phy_rx_data_o;
    end
endmodule // phy_rx_model

// ===== testbench.sv
// Self-checking bench for rx_ctrl_filter with an AXI4-Lite master.
// Assumes the consts header is in the include path.
`timescale 1ns/100ps
`include "rx_ctrl_consts.svh"
module testbench;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, tx_data = 8'h00, phy_byte = 8'h00, phy_data, rx_data;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, tx_valid = 1'b0;
    logic phy_send = 1'b0, phy_valid, fvalid = 1'b0, awready, wready, bvalid, arready, rvalid, irq;
    logic rx_valid, loop_act, acc_valid, acc;
    logic [3:0] fbits = 4'h0;
    logic [31:0] wdata = 32'h0, rd_word, rdata;
    logic [12:0] free_cnt = 13'h1;
    logic [47:0] dst = 48'h0;
    logic [1:0] bresp, rresp, resp;
    logic [16:0] buf_size;
    int fails = 0;
    int n_checks = 0;

    initial forever #2 clk_i = ~clk_i;

    rx_ctrl_filter rx_ctrl_filter_i (.clk_i, .rst_n_i, .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rd_word),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .irq_o(irq),
        .free_desc_count_i(free_cnt), .tx_data_i(tx_data), .tx_valid_i(tx_valid), .phy_rx_data_i(phy_data),
        .phy_rx_valid_i(phy_valid), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .loopback_active_o(loop_act),
        .frame_valid_i(fvalid), .frame_dst_addr_i(dst), .frame_addr_match_i(fbits[3]), .frame_tagged_i(fbits[2]),
        .frame_cfi_i(fbits[1]), .frame_vlan_hit_i(fbits[0]), .accept_valid_o(acc_valid), .accept_o(acc),
        .buffer_size_o(buf_size));
    phy_rx_model phy_rx_model_i (.clk_i, .send_i(phy_send), .byte_i(phy_byte), .phy_rx_data_o(phy_data),
        .phy_rx_valid_o(phy_valid));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t %s: seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // Address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_i);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            aw_ok |= (awready === 1'b1);
            w_ok |= (wready === 1'b1);
        end
        while (bvalid !== 1'b1) @(posedge clk_i);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk_i);
        rdata = rd_word;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic frame(input logic [47:0] d, input logic [3:0] f, input logic e);
        @(posedge clk_i);
        dst <= d;
        fbits <= f;
        fvalid <= 1'b1;
        @(posedge clk_i);
        fvalid <= 1'b0;
        @(posedge clk_i);
        chk(acc_valid, 1, "decision pulse");
        chk(acc, e, "decision");
    endtask

    task automatic t_regs;
        rd(`OFF_RECEIVE_CONTROL);
        chk(rdata, 32'h0, "control reset");
        rd(`OFF_SPLIT_BUF);
        chk(rdata, 32'h800, "split reset");
        wr(`OFF_RECEIVE_CONTROL, 32'hffffffff); // Reserved bits written one on purpose
        rd(`OFF_RECEIVE_CONTROL);
        chk(rdata, 32'h021fbfc0, "writable bits");
        wr(8'h80, 32'h1);
        chk(resp, 2'h2, "unmapped write");
        rd(8'h80);
        chk(resp, 2'h2, "unmapped read response");
        chk(rdata, 32'h0, "unmapped read data");
        $display("regs done");
    endtask

    task automatic t_bufsize;
        for (int x = 0; x < 2; x++) begin
            for (int b = 0; b < 4; b++) begin
                if (x == 1 && b == 0) continue; // Extended code 00b never programmed
                wr(`OFF_RECEIVE_CONTROL, (x << 25) | (b << 16));
                repeat (2) @(posedge clk_i);
                chk(buf_size, (2048 >> b) << (4 * x), "size");
            end
        end
        wr(`OFF_RECEIVE_CONTROL, 32'h00020400);
        wr(`OFF_SPLIT_BUF, 32'h1100);
        repeat (2) @(posedge clk_i);
        chk(buf_size, 32'h1100, "split size");
        wr(`OFF_FLEX_BUF, 32'h3);
        rd(`OFF_BUF_SIZE_STAT);
        chk(rdata, 32'd3072, "flex size");
        wr(`OFF_FLEX_BUF, 32'h0);
        $display("buffer size done");
    endtask

    task automatic t_thresh;
        wr(`OFF_RING_LENGTH, 32'd64);
        wr(`OFF_IRQ_MASK, 32'h1);
        rd(`OFF_IRQ_STATUS);
        for (int c = 0; c < 4; c++) begin
            free_cnt <= 13'h0;
            wr(`OFF_RECEIVE_CONTROL, c << 8);
            free_cnt <= 13'(64 >> (c + 1));
            repeat (3) @(posedge clk_i);
            chk(irq, c != 3, "threshold irq");
            rd(`OFF_IRQ_STATUS);
            chk(rdata, c != 3, "threshold flag");
            repeat (2) @(posedge clk_i);
            chk(irq, 0, "irq after clear");
        end
        wr(`OFF_IRQ_MASK, 32'h0);
        wr(`OFF_RECEIVE_CONTROL, 32'h0);
        free_cnt <= 13'd32;
        repeat (3) @(posedge clk_i);
        chk(irq, 0, "masked irq");
        rd(`OFF_IRQ_STATUS);
        chk(rdata, 32'h1, "masked flag");
        $display("threshold done");
    endtask

    task automatic t_mcast;
        logic [47:0] d;
        logic [11:0] ix;
        d = 48'h5ba3c7e19d42;
        for (int m = 0; m < 4; m++) begin
            ix = 12'(d >> (m == 3 ? 32 : 36 - m));
            wr(`OFF_RECEIVE_CONTROL, m << 12);
            wr(`OFF_MTA_INDEX, 32'(ix[11:5]));
            wr(`OFF_MTA_DATA, 32'h1 << ix[4:0]);
            frame(d, 4'h0, 1);
            wr(`OFF_MTA_DATA, ~(32'h1 << ix[4:0]));
            frame(d, 4'h0, 0);
        end
        wr(`OFF_MTA_DATA, 32'h0);
        $display("multicast done");
    endtask

    task automatic t_filters;
        wr(`OFF_RECEIVE_CONTROL, 32'h8000);
        frame('1, 4'h0, 1);
        wr(`OFF_RECEIVE_CONTROL, 32'h0);
        frame('1, 4'h0, 0);
        frame('1, 4'h8, 1);
        wr(`OFF_RECEIVE_CONTROL, 32'h40000);
        frame(48'h020000000001, 4'hc, 0);
        frame(48'h020000000001, 4'hd, 1);
        wr(`OFF_RECEIVE_CONTROL, 32'h0);
        frame(48'h020000000001, 4'hc, 1);
        wr(`OFF_RECEIVE_CONTROL, 32'h180000);
        frame(48'h020000000001, 4'he, 1);
        frame(48'h020000000001, 4'hc, 0);
        $display("filters done");
    endtask

    // Loopback chosen only by the MAC loopback select code, 01b
    task automatic t_loop;
        int n;
        for (int c = 0; c < 4; c++) begin
            wr(`OFF_RECEIVE_CONTROL, c << 6);
            repeat (2) @(posedge clk_i);
            chk(loop_act, c == 1, "loopback flag");
        end
        wr(`OFF_RECEIVE_CONTROL, 32'h40);
        repeat (2) @(posedge clk_i);
        tx_data <= 8'h5a;
        tx_valid <= 1'b1;
        @(posedge clk_i);
        tx_valid <= 1'b0;
        @(posedge clk_i);
        chk({rx_valid, rx_data}, 9'h15a, "looped byte");
        wr(`OFF_RECEIVE_CONTROL, 32'h0);
        repeat (2) @(posedge clk_i);
        phy_byte <= 8'hc3;
        phy_send <= 1'b1;
        tx_valid <= 1'b1;
        @(posedge clk_i);
        phy_send <= 1'b0;
        tx_valid <= 1'b0;
        n = 0;
        while (rx_valid !== 1'b1 && n < 8) begin
            @(posedge clk_i);
            n++;
        end
        chk({rx_valid, rx_data}, 9'h1c3, "phy byte");
        $display("loopback done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (30000) @(posedge clk_i);
        fails++;
        results();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        t_regs();
        t_bufsize();
        t_thresh();
        t_mcast();
        t_filters();
        t_loop();
        results();
    end
endmodule // testbench
